/* File: src/svm_pkg.sv */
package svm_pkg;

    // Register byte offsets
    localparam logic [11:0] SUPPLY_MONITOR_CONTROL_OFS = 12'h000;
    localparam logic [11:0] SVM_STATUS_OFS = 12'h004;
    localparam logic [11:0] SVM_SLEEP_OFS = 12'h008;

    // Field positions in the control register
    localparam int THR_LSB = 0;
    localparam int BGEN_BIT = 3;
    localparam int DETEN_BIT = 4;
    localparam int UVF_BIT = 5;

    // Status register fields
    localparam int IRQF_BIT = 0;
    localparam int WAKE_BIT = 1;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Stabilisation delay before the alarm flag sets
    localparam int ALARM_DELAY_NS = 1000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int ALARM_DELAY_CYC = (ALARM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // Trip level codes in millivolts
    localparam logic [15:0] THR_MV [8] = '{16'h0708, 16'h07d0, 16'h0960, 16'h0a8c,
                                           16'h0bb8, 16'h0ce4, 16'h0e10, 16'h0fa0};

    typedef struct packed {
        logic [2:0] threshold_select;
        logic bandgap_out_enable;
        logic detector_enable;
    } svm_ctrl_t;

endpackage

/* File: src/svm_top.sv */
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module svm_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic comparator_low,
    input wire logic brownout_reset_enable,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    output logic monitor_enable,
    output logic [2:0] trip_level_code,
    output logic [15:0] trip_level_mv,
    output logic reference_enable,
    output logic supply_alarm_irq,
    output logic idle_wakeup
);
    svm_pkg::svm_ctrl_t ctrl_q, ctrl_d;
    logic wr_pend_q, wr_pend_d;
    logic [11:0] addr_q, addr_d;
    logic sync1_q, sync1_d;
    logic sync2_q, sync2_d;
    logic uvf_q, uvf_d;
    logic irqf_q, irqf_d;
    logic [svm_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [31:0] rdata_d;
    logic men_q, men_d;
    logic ref_q, ref_d;
    logic wake_q, wake_d;
    logic [15:0] mv_q, mv_d;
    logic acc;
    logic wr_ctrl;
    logic wr_stat;
    logic mon_on;
    logic alarm_due;

    // Address phase accepted; this slave never inserts wait states
    assign acc = hsel && hready && htrans[1];
    assign wr_ctrl = wr_pend_q && (addr_q == svm_pkg::SUPPLY_MONITOR_CONTROL_OFS);
    assign wr_stat = wr_pend_q && (addr_q == svm_pkg::SVM_STATUS_OFS);
    assign mon_on = ctrl_q.detector_enable && !sleep_mode;
    assign alarm_due = uvf_q && (cnt_q == svm_pkg::CNT_W'(svm_pkg::ALARM_DELAY_CYC - 1));

    // Write data arrives one cycle after its address
    always_comb
    begin
        wr_pend_d = acc && hwrite;
        addr_d = addr_q;
        if (acc)
        begin
            addr_d = haddr[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            addr_q <= 12'h000;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            addr_q <= addr_d;
        end
    end

    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            ctrl_d.threshold_select = hwdata[svm_pkg::THR_LSB +: 3];
            ctrl_d.bandgap_out_enable = hwdata[svm_pkg::BGEN_BIT];
            ctrl_d.detector_enable = hwdata[svm_pkg::DETEN_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= svm_pkg::svm_ctrl_t'(svm_pkg::CTRL_RST[4:0]);
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // Comparator is analogue; two stages guard against metastability
    always_comb
    begin
        sync1_d = comparator_low;
        sync2_d = sync1_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    always_comb
    begin
        men_d = mon_on;
        ref_d = mon_on || brownout_reset_enable || ctrl_q.bandgap_out_enable;
        mv_d = svm_pkg::THR_MV[ctrl_q.threshold_select];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            men_q <= 1'b0;
            ref_q <= 1'b0;
            mv_q <= 16'h0000;
        end
        else
        begin
            men_q <= men_d;
            ref_q <= ref_d;
            mv_q <= mv_d;
        end
    end

    always_comb
    begin
        uvf_d = mon_on && sync2_q;
        cnt_d = cnt_q;
        if (!uvf_q)
        begin
            cnt_d = '0;
        end
        else if (cnt_q != svm_pkg::CNT_W'(svm_pkg::ALARM_DELAY_CYC))
        begin
            cnt_d = cnt_q + 1'b1;
        end
        // Software write of the alarm flag
        irqf_d = irqf_q;
        if (wr_stat)
        begin
            irqf_d = hwdata[svm_pkg::IRQF_BIT];
        end
        // hardware set wins over software clear
        if (alarm_due)
        begin
            irqf_d = 1'b1;
        end
        // idle wakeup only on a new request
        wake_d = idle_mode && irqf_d && !irqf_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            uvf_q <= 1'b0;
            cnt_q <= '0;
            irqf_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            uvf_q <= uvf_d;
            cnt_q <= cnt_d;
            irqf_q <= irqf_d;
            wake_q <= wake_d;
        end
    end

    // Read data stands until the next read address phase
    always_comb
    begin
        rdata_d = hrdata;
        if (acc && !hwrite)
        begin
            unique case (haddr[11:0])
                svm_pkg::SUPPLY_MONITOR_CONTROL_OFS:
                    rdata_d = {24'h0, 2'b00, uvf_q, ctrl_q.detector_enable,
                               ctrl_q.bandgap_out_enable, ctrl_q.threshold_select};
                svm_pkg::SVM_STATUS_OFS: rdata_d = {30'h0, wake_q, irqf_q};
                svm_pkg::SVM_SLEEP_OFS: rdata_d = {31'h0, sleep_mode};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else
        begin
            hrdata <= rdata_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign monitor_enable = men_q;
    assign trip_level_code = ctrl_q.threshold_select;
    assign trip_level_mv = mv_q;
    assign reference_enable = ref_q;
    assign supply_alarm_irq = irqf_q;
    assign idle_wakeup = wake_q;
endmodule
`default_nettype wire

/* File: tb/svm_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module svm_chk_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic comparator_low,
    input wire logic brownout_reset_enable,
    input wire logic sleep_mode,
    input wire logic monitor_enable,
    input wire logic [2:0] trip_level_code,
    input wire logic [15:0] trip_level_mv,
    input wire logic reference_enable,
    input wire logic supply_alarm_irq,
    input wire logic idle_wakeup
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    mv_map_a: assert property ($past(hresetn, 2) |-> trip_level_mv == svm_pkg::THR_MV[$past(trip_level_code)])
        else $error("trip level mv wrong");
    sleep_off_a: assert property (sleep_mode |=> !monitor_enable)
        else $error("monitor on in sleep");
    bor_ref_a: assert property (brownout_reset_enable |=> reference_enable)
        else $error("reference off with brownout reset");
    mon_ref_a: assert property (monitor_enable && $past(monitor_enable) |-> reference_enable)
        else $error("reference off with monitor on");
    alarm_delay_a: assert property ($rose(comparator_low) && monitor_enable && !supply_alarm_irq |=> !supply_alarm_irq [*8])
        else $error("alarm set too early");
    wake_pulse_a: assert property (idle_wakeup |=> !idle_wakeup)
        else $error("wakeup longer than one cycle");
    wake_cause_a: assert property (idle_wakeup |-> supply_alarm_irq)
        else $error("wakeup without alarm");
    cover property ($rose(supply_alarm_irq));
    cover property (idle_wakeup);
    cover property (sleep_mode && brownout_reset_enable && reference_enable);
endmodule
bind svm_top svm_chk_monitor u_mon (.*);
`default_nettype wire

/* File: tb/svm_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module svm_top_tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, monitor_enable;
    logic comparator_low = 1'b0, brownout_reset_enable = 1'b0, sleep_mode = 1'b0, idle_mode = 1'b0;
    logic reference_enable, supply_alarm_irq, idle_wakeup;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, trip_level_code;
    logic [15:0] trip_level_mv;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    wire hready = hreadyout;
    int mismatches = 0, tests_run = 0, wakes = 0;
    int mv[8] = '{1800, 2000, 2400, 2700, 3000, 3300, 3600, 4000};
    realtime t;
    svm_top uut (.*);
    initial forever #4 hclk = ~hclk;
    always @(posedge hclk) wakes <= wakes + int'(idle_wakeup === 1'b1);
    task automatic results;
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk iff hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        // Taken before this edge's updates land
        @(posedge hclk iff hreadyout);
        r = hrdata;
    endtask
    task automatic t_regs;
        xfer(1'b0, 32'h0, 32'h0);
        cmp("ctrl", 32'h0, r);
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, 32'h0, 32'hffffffe8 | i);
            xfer(1'b0, 32'h0, 32'h0);
            cmp("ctrl", 32'h8 | i, r);
            cmp("mv", mv[i], trip_level_mv);
            cmp("code", i, trip_level_code);
        end
        cmp("ref", 32'h1, reference_enable);
    endtask
    task automatic t_sleep;
        xfer(1'b1, 32'h0, 32'h10);
        xfer(1'b0, 32'h0, 32'h0);
        cmp("mon", 32'h1, monitor_enable);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        cmp("sleep", 32'h0, {monitor_enable, reference_enable});
        brownout_reset_enable <= 1'b1;
        repeat (3) @(posedge hclk);
        cmp("bor", 32'h1, reference_enable);
        sleep_mode <= 1'b0;
        brownout_reset_enable <= 1'b0;
    endtask
    task automatic t_alarm;
        @(posedge hclk);
        idle_mode <= 1'b1;
        comparator_low <= 1'b1;
        t = $realtime;
        @(posedge hclk iff supply_alarm_irq);
        cmp("delay", 32'h1, ($realtime - t) >= 1000 && ($realtime - t) <= 1064);
        xfer(1'b0, 32'h0, 32'h0);
        cmp("uvf", 32'h30, r);
        xfer(1'b0, 32'h4, 32'h0);
        cmp("irq", 32'h1, r & 32'h1);
        cmp("wake", 32'h1, wakes);
        comparator_low <= 1'b0;
        xfer(1'b1, 32'h4, 32'h1);
        comparator_low <= 1'b1;
        repeat (150) @(posedge hclk);
        cmp("nowake", 32'h1, wakes);
    endtask
    initial
    begin
        #20000;
        mismatches++;
        results();
    end
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_sleep();
        t_alarm();
        results();
    end
endmodule
`default_nettype wire
